// >>> src/scirq_top.sv
/*
  Select code recognition, interrupt line decode and power-on self-test.
  Assumes host address and strobe come from the backplane (asynchronous),
  and interrupt enable, request and self-test result come from card logic
  on mclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "scirq_consts.svh"

module scirq_top
  import scirq_pkg::*;
(
  // Clock and reset
  input  wire logic                     mclk,
  input  wire logic                     rst_n,
  // Switches
  input  wire logic [`SCIRQ_SW_W-1:0]   config_switch_pack,
  // Host bus
  input  wire logic [`SCIRQ_ADDR_W-1:0] host_addr_upper,
  input  wire logic                     host_address_strobe,
  output logic                          addressed_ack,
  // Card-side interrupt control
  input  wire logic                     irq_enable,
  input  wire logic                     irq_request,
  // Interrupt request lines, levels 3..6
  output logic                          irq_line_lowest,
  output logic                          irq_line_4,
  output logic                          irq_line_5,
  output logic                          irq_line_highest,
  // Self-test
  input  wire logic                     selftest_error,
  output logic                          selftest_done,
  output logic                          card_failed
);
  scirq_cfg_if cfg ();

  scirq_switch_capture u_cap (
    .mclk               (mclk),
    .rst_n              (rst_n),
    .config_switch_pack (config_switch_pack),
    .cfg                (cfg.cap)
  );

  // Three-stage sync of host address and strobe (8 + 1 bits).
  // The ack therefore lags the pins by four cycles; a host that drops
  // strobe after fewer than two cycles is never acknowledged.
  localparam int unsigned HW = `SCIRQ_ADDR_W + 1;
  logic [HW-1:0] h1_q, h2_q, h3_q, h1_d, h2_d, h3_d;
  logic          ack_q, ack_d;
  logic [HW-1:0] host_s;

  // Compare only once stages agree, so a moving address is ignored
  always_comb begin
    h1_d   = {host_address_strobe, host_addr_upper};
    h2_d   = h1_q;
    h3_d   = h2_q;
    host_s = h3_q;
    ack_d  = 1'b0;
    if ((h2_q == h3_q) && host_s[HW-1] && cfg.cfg_valid &&
        (host_s[`SCIRQ_SEL_W-1:0] == cfg.sel_code) &&
        (host_s[`SCIRQ_ADDR_W-1:`SCIRQ_SEL_W] == '0)) begin
      ack_d = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      h1_q  <= '0;
      h2_q  <= '0;
      h3_q  <= '0;
      ack_q <= 1'b0;
    end else begin
      h1_q  <= h1_d;
      h2_q  <= h2_d;
      h3_q  <= h3_d;
      ack_q <= ack_d;
    end
  end

  assign addressed_ack = ack_q;

  // Interrupt line decode; one line per level
  // A failed card keeps every line low so it never asks for service
  logic [`SCIRQ_LINE_W-1:0] lines_q, lines_d;
  always_comb begin
    lines_d = '0;
    if (irq_enable && irq_request && cfg.cfg_valid && !card_failed) begin
      lines_d[cfg.irq_level] = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lines_q <= '0;
    end else begin
      lines_q <= lines_d;
    end
  end

  assign irq_line_lowest  = lines_q[0];
  assign irq_line_4       = lines_q[1];
  assign irq_line_5       = lines_q[2];
  assign irq_line_highest = lines_q[3];

  // Self-test: runs a fixed window after reset, an error within the window latches a fail.
  // The test itself is card firmware; this only sequences and reports.
  scirq_state_t st_q, st_d;
  logic [`SCIRQ_TEST_CNT_W-1:0] cnt_q, cnt_d;
  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    unique case (st_q)
      SCIRQ_ST_RESET: begin
        if (cfg.cfg_valid) begin
          st_d  = SCIRQ_ST_TEST;
          cnt_d = '0;
        end
      end
      SCIRQ_ST_TEST: begin
        if (selftest_error) begin
          st_d = SCIRQ_ST_FAIL;
        end else if (cnt_q == `SCIRQ_TEST_CYCLES - 8'h01) begin
          st_d = SCIRQ_ST_PASS;
        end else begin
          cnt_d = cnt_q + 8'h01;
        end
      end
      SCIRQ_ST_PASS: st_d = SCIRQ_ST_PASS;
      SCIRQ_ST_FAIL: st_d = SCIRQ_ST_FAIL;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q  <= SCIRQ_ST_RESET;
      cnt_q <= '0;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
    end
  end

  assign selftest_done = (st_q == SCIRQ_ST_PASS) || (st_q == SCIRQ_ST_FAIL);
  assign card_failed   = (st_q == SCIRQ_ST_FAIL);

  // Assertions
  sequence s_req;
    irq_enable && irq_request && cfg.cfg_valid && !card_failed;
  endsequence

  // Self-test entry, the start point of the bounded run checked below
  sequence s_test_entry;
    $rose(st_q == SCIRQ_ST_TEST);
  endsequence

  // Interrupt lines
  irq_onehot_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $onehot0(lines_q)) else $error("more than one request line");
  irq_level_a: assert property (@(posedge mclk) disable iff (!rst_n)
    s_req |=> lines_q[$past(cfg.irq_level)])
    else $error("wrong request line");
  irq_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !(irq_enable && irq_request) |=> lines_q == '0)
    else $error("request line without cause");
  fail_quiet_a: assert property (@(posedge mclk) disable iff (!rst_n)
    card_failed |=> lines_q == '0)
    else $error("request line on a failed card");

  // Host acknowledge
  ack_match_a: assert property (@(posedge mclk) disable iff (!rst_n)
    addressed_ack |-> $past(host_s[`SCIRQ_SEL_W-1:0]) == cfg.sel_code
      && $past(host_s[HW-1]))
    else $error("ack without match");
  ack_strobe_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !host_address_strobe [*4] |-> !addressed_ack)
    else $error("ack without strobe");
  ack_upper_a: assert property (@(posedge mclk) disable iff (!rst_n)
    addressed_ack |->
      $past(host_s[`SCIRQ_ADDR_W-1:`SCIRQ_SEL_W]) == '0)
    else $error("ack with upper address bits set");
  ack_wait_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !cfg.cfg_valid |=> !addressed_ack)
    else $error("ack before settings captured");

  // Settings capture and self-test
  sel_map_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(cfg.cfg_valid) |->
      (cfg.sel_code ==
        $past(config_switch_pack[`SCIRQ_SEL_MSB:`SCIRQ_SEL_LSB], 4)) &&
      (cfg.irq_level ==
        $past(config_switch_pack[`SCIRQ_LVL_MSB:`SCIRQ_LVL_LSB], 4)))
    else $error("select code map");
  test_start_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(cfg.cfg_valid) |=> st_q == SCIRQ_ST_TEST)
    else $error("self-test did not start");
  test_fail_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_q == SCIRQ_ST_TEST && selftest_error) |=> card_failed [*2])
    else $error("failure not reported");
  test_end_a: assert property (@(posedge mclk) disable iff (!rst_n)
    s_test_entry |-> ##[1:16] selftest_done)
    else $error("self-test did not finish");
  cnt_window_a: assert property (@(posedge mclk) disable iff (!rst_n)
    st_q == SCIRQ_ST_TEST |-> cnt_q < `SCIRQ_TEST_CYCLES)
    else $error("self-test ran past its window");
  pass_clean_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(st_q == SCIRQ_ST_PASS) |-> !$past(selftest_error))
    else $error("self-test passed despite an error");
  done_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    selftest_done |=> selftest_done && $stable(card_failed))
    else $error("self-test verdict changed");
endmodule // scirq_top

`default_nettype wire

// >>> src/scirq_consts.svh
/*
  Constants for the select code and interrupt level configuration block.
  Assumes inclusion by bare name from the package and the design files.
*/
`ifndef SCIRQ_CONSTS_SVH
`define SCIRQ_CONSTS_SVH

// Switch pack layout
`define SCIRQ_SW_W          8
`define SCIRQ_SEL_MSB       4
`define SCIRQ_SEL_LSB       0
`define SCIRQ_LVL_MSB       6
`define SCIRQ_LVL_LSB       5
`define SCIRQ_SEL_W         5
`define SCIRQ_ADDR_W        8
// Factory settings: select code 20, level switches 00
`define SCIRQ_SEL_DEFAULT   5'h14
`define SCIRQ_LVL_DEFAULT   2'h0
// Interrupt lines for levels 3 to 6
`define SCIRQ_NUM_LINES     4
`define SCIRQ_LINE_W        4
// Self-test
`define SCIRQ_TEST_CYCLES   8'h10
`define SCIRQ_TEST_CNT_W    8

`endif

// >>> src/scirq_pkg.sv
/*
  Types for the select code and interrupt level configuration block.
  Assumes the constants header is on the include path.
*/
`default_nettype none
`include "scirq_consts.svh"

package scirq_pkg;
  // Self-test sequencer, Gray coded from RESET to TEST to PASS; TEST to FAIL flips both bits
  typedef enum logic [1:0] {
    SCIRQ_ST_RESET = 2'b00,
    SCIRQ_ST_TEST  = 2'b01,
    SCIRQ_ST_PASS  = 2'b11,
    SCIRQ_ST_FAIL  = 2'b10
  } scirq_state_t;
endpackage

`default_nettype wire

// >>> src/scirq_cfg_if.sv
/*
  Carrier between the configuration capture and the top module.
  Assumes one clock domain; no clocking block.
*/
`timescale 1ns/1ps
`default_nettype none
`include "scirq_consts.svh"

interface scirq_cfg_if;
  logic [`SCIRQ_SEL_W-1:0] sel_code;
  logic [1:0]              irq_level;
  logic                    cfg_valid;
  modport cap (output sel_code, output irq_level, output cfg_valid);
  modport use_side (input sel_code, input irq_level, input cfg_valid);
endinterface

`default_nettype wire

// >>> src/scirq_switch_capture.sv
/*
  Switch pack capture: synchronises the static switches and latches them
  once after reset release. Assumes switches are raw pins, not mclk logic.
*/
`timescale 1ns/1ps
`default_nettype none
`include "scirq_consts.svh"

module scirq_switch_capture
  import scirq_pkg::*;
(
  // Clock and reset
  input  wire logic                    mclk,
  input  wire logic                    rst_n,
  // Raw switches
  input  wire logic [`SCIRQ_SW_W-1:0]  config_switch_pack,
  // Captured settings
  scirq_cfg_if.cap                     cfg
);
  logic [`SCIRQ_SW_W-1:0] s1_q, s2_q, s3_q;
  logic [`SCIRQ_SW_W-1:0] s1_d, s2_d, s3_d;
  logic [`SCIRQ_SEL_W-1:0] sel_q, sel_d;
  logic [1:0]              lvl_q, lvl_d;
  logic                    vld_q, vld_d;
  logic [1:0]              fill_q, fill_d;

  // Latch only when stages two and three agree, so a bouncing rocker
  // never lands in the settings; the fill count stops the reset zeros
  // still in the stages from passing as an agreeing switch value
  always_comb begin
    s1_d   = config_switch_pack;
    s2_d   = s1_q;
    s3_d   = s2_q;
    sel_d  = sel_q;
    lvl_d  = lvl_q;
    vld_d  = vld_q;
    fill_d = fill_q;
    if (fill_q != 2'h3) begin
      fill_d = fill_q + 2'h1;
    end
    if (!vld_q && (fill_q == 2'h3) && (s2_q == s3_q)) begin
      sel_d = s3_q[`SCIRQ_SEL_MSB:`SCIRQ_SEL_LSB];
      lvl_d = s3_q[`SCIRQ_LVL_MSB:`SCIRQ_LVL_LSB];
      vld_d = 1'b1;
    end
  end

  // Registers; sel_q and lvl_q reset to the factory settings, the rest to zeros
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      sel_q <= `SCIRQ_SEL_DEFAULT;
      lvl_q <= `SCIRQ_LVL_DEFAULT;
      vld_q <= 1'b0;
      fill_q <= 2'h0;
    end else begin
      s1_q  <= s1_d;
      s2_q  <= s2_d;
      s3_q  <= s3_d;
      sel_q <= sel_d;
      lvl_q <= lvl_d;
      vld_q <= vld_d;
      fill_q <= fill_d;
    end
  end

  assign cfg.sel_code  = sel_q;
  assign cfg.irq_level = lvl_q;
  assign cfg.cfg_valid = vld_q;

  // Settings stay frozen once captured
  sel_frozen_a: assert property (@(posedge mclk) disable iff (!rst_n)
    vld_q |=> $stable(sel_q) && $stable(lvl_q))
    else $error("settings changed after capture");

  // Capture never takes the reset zeros still in the stages
  fill_wait_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(vld_q) |-> $past(fill_q) == 2'h3)
    else $error("settings captured before the stages filled");
endmodule // scirq_switch_capture

`default_nettype wire

// >>> tb/scirq_host_model.sv
/*
  Host processor model: drives the upper address bits and the strobe,
  watches the acknowledge, and picks the interrupt level to serve.
  Assumes it runs on the card clock and owns the host bus pins alone.
*/
`timescale 1ns/1ps
`default_nettype none
`include "scirq_consts.svh"

module scirq_host_model (
  // Clock
  input  wire logic                     mclk,
  // Host bus
  output logic [`SCIRQ_ADDR_W-1:0]      host_addr_upper,
  output logic                          host_address_strobe,
  input  wire logic                     addressed_ack,
  // Request lines, levels 3 to 6
  input  wire logic [3:0]               irq_lines
);
  initial begin
    host_addr_upper     = 8'hff;
    host_address_strobe = 1'b0;
  end

  // One access; held until ack is sampled or the wait runs out
  task automatic access(input logic [7:0] a, output logic seen);
    int n;
    @(negedge mclk);
    host_addr_upper     = a;
    host_address_strobe = 1'b1;
    n = 0;
    seen = 1'b0;
    while (n < 10 && seen !== 1'b1) begin
      @(posedge mclk);
      seen = addressed_ack;
      n++;
    end
    @(negedge mclk);
    host_address_strobe = 1'b0;
    host_addr_upper     = ~a; // Released bus has no pull, so not last value
    repeat (6) @(negedge mclk); // Ack lags the strobe drop by three cycles
  endtask

  // Highest pending level is served first; only levels 3 to 6 exist
  function automatic logic [3:0] level(input logic [3:0] l);
    level = 4'h0;
    for (int i = 0; i < 4; i++) begin
      if (l[i] === 1'b1) begin
        level = 4'(i + 3);
      end
    end
  endfunction
endmodule // scirq_host_model

`default_nettype wire

// >>> tb/scirq_top_bench.sv
/*
  Self-checking bench for the select code and interrupt level block.
  Assumes the host model stands on the host bus; switches are static.
*/
`timescale 1ns/1ps
`default_nettype none
`include "scirq_consts.svh"

module scirq_top_bench;
  logic       mclk = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] sw = 8'h14;
  logic       irq_enable = 1'b0;
  logic       irq_request = 1'b0;
  logic       selftest_error = 1'b0;
  logic [7:0] addr;
  logic       strobe, ack, done, failed, a;
  logic [3:0] lines;
  int         n_fail = 0;
  int         compares = 0;
  int         cycles = 0;

  always #12.5 mclk = ~mclk;

  scirq_top DUT (.mclk(mclk), .rst_n(rst_n), .config_switch_pack(sw),
    .host_addr_upper(addr), .host_address_strobe(strobe),
    .addressed_ack(ack), .irq_enable(irq_enable),
    .irq_request(irq_request), .irq_line_lowest(lines[0]),
    .irq_line_4(lines[1]), .irq_line_5(lines[2]),
    .irq_line_highest(lines[3]), .selftest_error(selftest_error),
    .selftest_done(done), .card_failed(failed));

  scirq_host_model HOST (.mclk(mclk), .host_addr_upper(addr),
    .host_address_strobe(strobe), .addressed_ack(ack), .irq_lines(lines));

  task automatic tally_and_finish;
    if (n_fail == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [3:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Power-on: switches set under reset, self-test waited for
  task automatic boot(input logic [7:0] s, input logic err);
    int n;
    @(negedge mclk);
    rst_n = 1'b0;
    sw = s;
    selftest_error = err;
    repeat (20) @(negedge mclk);
    rst_n = 1'b1;
    n = 0;
    while (n < 60 && done !== 1'b1) begin
      @(negedge mclk);
      n++;
    end
    check("selftest_done", {3'h0, done}, 4'h1);
    selftest_error = 1'b0;
  endtask

  // Request service, then withdraw it with interrupts still enabled
  task automatic irq(input int lvl, input logic ok);
    logic [3:0] exp;
    exp = ok ? 4'(1 << (lvl - 3)) : 4'h0;
    @(negedge mclk);
    irq_enable = 1'b1;
    irq_request = 1'b1;
    repeat (2) @(negedge mclk);
    check("irq lines", lines, exp);
    check("served level", HOST.level(lines), ok ? 4'(lvl) : 4'h0);
    irq_request = 1'b0;
    repeat (2) @(negedge mclk);
    check("irq lines idle", lines, 4'h0);
    irq_enable = 1'b0;
    irq_request = 1'b1;
    repeat (2) @(negedge mclk);
    check("irq disabled", lines, 4'h0);
    irq_request = 1'b0;
  endtask

  task automatic t_default;
    boot(8'h14, 1'b0);
    check("card_failed", {3'h0, failed}, 4'h0);
    HOST.access(8'h14, a);
    check("ack code 20", {3'h0, a}, 4'h1);
    HOST.access(8'h15, a);
    check("ack code 21", {3'h0, a}, 4'h0);
    HOST.access(8'h34, a);
    check("ack upper bits", {3'h0, a}, 4'h0);
    sw = 8'h6b; // Switches moved after capture must be ignored
    HOST.access(8'h14, a);
    check("ack after switch move", {3'h0, a}, 4'h1);
    irq(3, 1'b1);
  endtask

  // Every level setting, each with its own legal select code
  task automatic t_levels;
    logic [4:0] c;
    for (int i = 0; i < 4; i++) begin
      c = (i == 3) ? 5'h1f : 5'(8 + 7 * i);
      boot({1'b0, 2'(i), c}, 1'b0);
      HOST.access({3'h0, c}, a);
      check("ack own code", {3'h0, a}, 4'h1);
      HOST.access({3'h0, c ^ 5'h10}, a);
      check("ack msb flipped", {3'h0, a}, 4'h0);
      irq(3 + i, 1'b1);
    end
  endtask

  task automatic t_failed;
    boot(8'h14, 1'b1);
    check("card_failed", {3'h0, failed}, 4'h1);
    irq(3, 1'b0);
  endtask

  // Whole run is about 450 cycles; the ceiling leaves ample margin
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  initial begin
    t_default();
    t_levels();
    t_failed();
    tally_and_finish();
  end
endmodule // scirq_top_bench

`default_nettype wire
